// [rtl/uspf_pkg.sv]
`default_nettype none

// shared constants and types for the serial port status flag block
package uspf_pkg;

    // register byte offsets on the plain register port
    localparam logic [7:0] USPF_OFS_CTRL  = 8'h00; // interrupt enables, modes
    localparam logic [7:0] USPF_OFS_CMD   = 8'h18; // flush commands
    localparam logic [7:0] USPF_OFS_STAT  = 8'h1C; // serial_line_status
    localparam logic [7:0] USPF_OFS_CLR   = 8'h20; // flag_clear_reg
    localparam logic [7:0] USPF_OFS_RDATA = 8'h24; // receive data
    localparam logic [7:0] USPF_OFS_TDATA = 8'h28; // transmit data

    // status and clear bit positions (enables share the layout)
    localparam int unsigned USPF_B_PAR = 0;  // parity error
    localparam int unsigned USPF_B_FRM = 1;  // framing error
    localparam int unsigned USPF_B_NOI = 2;  // noise error
    localparam int unsigned USPF_B_OVR = 3;  // overrun
    localparam int unsigned USPF_B_IDL = 4;  // idle line
    localparam int unsigned USPF_B_RXF = 5;  // receive buffer full
    localparam int unsigned USPF_B_TXC = 6;  // transmission complete
    localparam int unsigned USPF_B_TXE = 7;  // transmit buffer empty
    localparam int unsigned USPF_B_LIN = 8;  // lin break
    localparam int unsigned USPF_B_CHG = 9;  // clear-to-send change
    localparam int unsigned USPF_B_LVL = 10; // clear-to-send level
    localparam int unsigned USPF_NFLAG = 10; // number of sticky flags

    // control register mode bits and command bits
    localparam int unsigned USPF_B_MB   = 16; // multibuffer mode
    localparam int unsigned USPF_B_SC   = 17; // smartcard mode
    localparam int unsigned USPF_B_RXFL = 0;  // receive flush command
    localparam int unsigned USPF_B_TXFL = 1;  // transmit flush command

    // data character width
    localparam int unsigned USPF_DW = 9;

    // reset values: both transmit flags start set, line is quiet
    localparam logic [9:0]  USPF_FLAG_RST = 10'h0C0;
    localparam logic [31:0] USPF_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] USPF_ZERO     = 32'h0000_0000;
    localparam logic [8:0]  USPF_WORD_RST = 9'h000;

    // one-cycle event pulses from the shifters and line detectors
    typedef struct packed {
        logic lin_break;  // lin break seen on receive line
        logic tx_load;    // transmit data moved into shift register
        logic tx_done;    // frame with data finished shifting out
        logic rx_ready;   // received word ready for the data register
        logic idle;       // idle line seen
        logic noise;      // noise on a received frame
        logic framing;    // desync, heavy noise or break character
        logic parity;     // parity error on reception
        logic sc_nack;    // smartcard retries exhausted after refusals
    } uspf_evt_s;

endpackage : uspf_pkg

`default_nettype wire

// [rtl/uspf_status.sv]
`default_nettype none

module uspf_status
    import uspf_pkg::*;
#(
    parameter bit HAS_LIN = 1'b1 // clear on the second port instance
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic        clear_to_send_in_n,
    input  wire uspf_evt_s   evt,
    input  wire logic [8:0]  rx_word,
    output logic      [8:0]  tx_word,
    output logic             tx_word_valid,
    output logic             irq
);

    // register state
    logic [9:0]  flag_reg;    // sticky flags, bits 9..0 of status
    logic [31:0] ctrl_reg;    // enables and mode bits
    logic [8:0]  rx_data_reg; // receive data register
    logic [8:0]  tx_data_reg; // transmit data register
    logic        cts_prev_reg;  // pin level one cycle back
    logic        idle_arm_reg;  // idle flag may set again
    logic [31:0] rd_data_reg; // read answer, valid one cycle later

    // decoded accesses
    logic wr_ctrl;
    logic wr_cmd;
    logic wr_clr;
    logic wr_tdata;
    logic rd_rdata;
    logic rx_flush;
    logic tx_flush;

    // per-flag set and clear terms
    logic [9:0] flag_set;
    logic [9:0] flag_clr;
    logic       idle_set;
    logic       rx_take;
    logic       cts_toggle;
    logic       multibuf;
    logic       err_irq;
    logic [31:0] status_w;

    // register port decode; status is read-only so no write strobe
    assign wr_ctrl  = wr_en && (addr == USPF_OFS_CTRL);
    assign wr_cmd   = wr_en && (addr == USPF_OFS_CMD);
    assign wr_clr   = wr_en && (addr == USPF_OFS_CLR);
    assign wr_tdata = wr_en && (addr == USPF_OFS_TDATA);
    assign rd_rdata = rd_en && (addr == USPF_OFS_RDATA);
    assign rx_flush = wr_cmd && wr_data[USPF_B_RXFL];
    assign tx_flush = wr_cmd && wr_data[USPF_B_TXFL];
    assign multibuf = ctrl_reg[USPF_B_MB];

    // pin is synchronous to clock, so a plain one-cycle compare works
    assign cts_toggle = clear_to_send_in_n != cts_prev_reg;

    // word moves into the data register only when the register is free
    assign rx_take  = evt.rx_ready && !flag_reg[USPF_B_RXF];
    assign idle_set = evt.idle && idle_arm_reg;

    // set conditions, one per flag
    always_comb begin
        flag_set             = '0;
        flag_set[USPF_B_CHG] = cts_toggle;
        flag_set[USPF_B_LIN] = HAS_LIN && evt.lin_break;
        flag_set[USPF_B_TXE] = evt.tx_load || tx_flush;
        // a frame ending with the buffer still full leaves complete low
        flag_set[USPF_B_TXC] = evt.tx_done && flag_reg[USPF_B_TXE];
        flag_set[USPF_B_RXF] = rx_take;
        flag_set[USPF_B_IDL] = idle_set;
        flag_set[USPF_B_OVR] = evt.rx_ready && flag_reg[USPF_B_RXF];
        flag_set[USPF_B_NOI] = evt.noise;
        flag_set[USPF_B_FRM] = evt.framing ||
                               (ctrl_reg[USPF_B_SC] && evt.sc_nack);
        flag_set[USPF_B_PAR] = evt.parity;
    end

    // clear conditions; the two buffer flags have their own clears
    always_comb begin
        flag_clr             = wr_clr ? wr_data[9:0] : '0;
        flag_clr[USPF_B_TXE] = wr_tdata;
        flag_clr[USPF_B_RXF] = rd_rdata || rx_flush;
    end

    // sticky flags: an event in the clearing cycle still lands, so
    // software never loses a flag by clearing it at a bad moment
    genvar gi;
    generate
        for (gi = 0; gi < USPF_NFLAG; gi++) begin : g_flag
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    flag_reg[gi] <= USPF_FLAG_RST[gi];
                end else begin
                    // status writes never reach here
                    flag_reg[gi] <= flag_set[gi] ||
                                    (flag_reg[gi] && !flag_clr[gi]);
                end
            end
        end
    endgenerate

    // previous pin level for change detection; starts as idle high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cts_prev_reg <= 1'b1;
        end else begin
            cts_prev_reg <= clear_to_send_in_n;
        end
    end

    // idle flag sets once per quiet spell; the next word taken into the
    // data register rearms it, so a long idle line does not raise it repeatedly
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_arm_reg <= 1'b1;
        end else if (rx_take) begin
            idle_arm_reg <= 1'b1;
        end else if (idle_set) begin
            idle_arm_reg <= 1'b0;
        end
    end

    // control register: enables in flag layout, modes above
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg <= USPF_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= wr_data;
        end
    end

    // receive data register; on overrun the old word is kept
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data_reg <= USPF_WORD_RST;
        end else if (rx_take) begin
            rx_data_reg <= rx_word;
        end
    end

    // transmit data register, handed to the shifter while not empty
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_data_reg <= USPF_WORD_RST;
        end else if (wr_tdata) begin
            tx_data_reg <= wr_data[8:0];
        end
    end

    assign tx_word       = tx_data_reg;
    assign tx_word_valid = !flag_reg[USPF_B_TXE];

    // status word as software sees it
    always_comb begin
        status_w             = USPF_ZERO;
        status_w[9:0]        = flag_reg;
        status_w[USPF_B_LVL] = !clear_to_send_in_n;
    end

    // read mux; unmapped and write-only offsets answer zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_reg <= USPF_ZERO;
        end else if (rd_en) begin
            case (addr)
                USPF_OFS_CTRL:  rd_data_reg <= ctrl_reg;
                USPF_OFS_STAT:  rd_data_reg <= status_w;
                USPF_OFS_RDATA: rd_data_reg <= {23'h00_0000, rx_data_reg};
                USPF_OFS_TDATA: rd_data_reg <= {23'h00_0000, tx_data_reg};
                default:        rd_data_reg <= USPF_ZERO;
            endcase
        end else begin
            rd_data_reg <= USPF_ZERO;
        end
    end

    assign rd_data = rd_data_reg;

    // error enable only reaches the line in multibuffer mode
    assign err_irq = multibuf && ctrl_reg[USPF_B_OVR] &&
                     (flag_reg[USPF_B_OVR] || flag_reg[USPF_B_NOI] ||
                      flag_reg[USPF_B_FRM]);

    // interrupt level; overrun rides on the full-buffer enable too
    assign irq = (flag_reg[USPF_B_CHG] && ctrl_reg[USPF_B_CHG]) ||
                 (flag_reg[USPF_B_LIN] && ctrl_reg[USPF_B_LIN]) ||
                 (flag_reg[USPF_B_TXE] && ctrl_reg[USPF_B_TXE]) ||
                 (flag_reg[USPF_B_TXC] && ctrl_reg[USPF_B_TXC]) ||
                 (flag_reg[USPF_B_RXF] && ctrl_reg[USPF_B_RXF]) ||
                 (flag_reg[USPF_B_IDL] && ctrl_reg[USPF_B_IDL]) ||
                 (flag_reg[USPF_B_OVR] && ctrl_reg[USPF_B_RXF]) ||
                 (flag_reg[USPF_B_PAR] && ctrl_reg[USPF_B_PAR]) ||
                 err_irq;

    // checks on the flag behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // a status read answers the pin level of the read cycle
    sequence s_stat_read;
        rd_en && (addr == USPF_OFS_STAT);
    endsequence

    AST_LEVEL_READ: assert property (
        s_stat_read |=> rd_data[USPF_B_LVL] == !$past(clear_to_send_in_n))
        else $error("level bit does not follow the pin");

    AST_CHANGE_SET: assert property (
        $changed(clear_to_send_in_n) |=> flag_reg[USPF_B_CHG])
        else $error("pin toggle missed");

    AST_LIN_RESERVED: assert property (
        !HAS_LIN |-> !flag_reg[USPF_B_LIN])
        else $error("lin flag set on instance without lin");

    AST_TXE_FLUSH: assert property (
        (wr_en && addr == USPF_OFS_CMD && wr_data[USPF_B_TXFL])
        |=> flag_reg[USPF_B_TXE] && !tx_word_valid)
        else $error("transmit flush did not empty buffer");

    AST_TXE_CLEAR: assert property (
        (wr_en && addr == USPF_OFS_TDATA && !evt.tx_load)
        |=> !flag_reg[USPF_B_TXE] && tx_word_valid)
        else $error("data write did not clear empty flag");

    AST_TXC_CAUSE: assert property (
        $rose(flag_reg[USPF_B_TXC])
        |-> $past(evt.tx_done) && $past(flag_reg[USPF_B_TXE]))
        else $error("complete flag set without finished frame");

    AST_RXF_CLEAR: assert property (
        (rd_en && addr == USPF_OFS_RDATA && !evt.rx_ready)
        |=> !flag_reg[USPF_B_RXF])
        else $error("data read did not clear full flag");

    // once idle has set, a further quiet spell with no word taken
    // in between must leave the flag alone, even after a clear
    sequence s_idle_blocked;
        !idle_arm_reg && evt.idle && !flag_reg[USPF_B_IDL];
    endsequence

    AST_IDLE_ONCE: assert property (
        s_idle_blocked |=> !flag_reg[USPF_B_IDL])
        else $error("idle flag set twice without a new word");

    AST_OVERRUN: assert property (
        (evt.rx_ready && flag_reg[USPF_B_RXF])
        |=> flag_reg[USPF_B_OVR] && $stable(rx_data_reg))
        else $error("overrun not flagged or word overwritten");

    AST_ERR_IRQ: assert property (
        (multibuf && ctrl_reg[USPF_B_OVR] && flag_reg[USPF_B_NOI]) |-> irq)
        else $error("noise error did not interrupt");

    AST_PARITY_IRQ: assert property (
        evt.parity ##1 ctrl_reg[USPF_B_PAR] |-> irq)
        else $error("parity error did not interrupt");

    AST_CLEAR_OVR: assert property (
        (wr_clr && wr_data[USPF_B_OVR] && !flag_set[USPF_B_OVR])
        |=> !flag_reg[USPF_B_OVR])
        else $error("overrun not cleared by clear register");

    AST_STAT_RO: assert property (
        (wr_en && addr == USPF_OFS_STAT && flag_set == '0)
        |=> flag_reg == $past(flag_reg))
        else $error("status write changed a flag");

    // set paths of the remaining flags, one pulse each, and the receive flush clear
    AST_LIN_SET: assert property (
        (HAS_LIN && evt.lin_break) |=> flag_reg[USPF_B_LIN])
        else $error("lin break not flagged");

    // the word of the taking cycle lands in the data register
    AST_RXF_SET: assert property (
        (evt.rx_ready && !flag_reg[USPF_B_RXF])
        |=> flag_reg[USPF_B_RXF] && rx_data_reg == $past(rx_word))
        else $error("received word not taken");

    AST_RXF_FLUSH: assert property (
        (wr_en && addr == USPF_OFS_CMD && wr_data[USPF_B_RXFL] &&
         !evt.rx_ready) |=> !flag_reg[USPF_B_RXF])
        else $error("receive flush did not clear full flag");

    AST_NOISE_SET: assert property (
        evt.noise |=> flag_reg[USPF_B_NOI])
        else $error("noise error not flagged");

    AST_FRAMING_SET: assert property (
        evt.framing |=> flag_reg[USPF_B_FRM])
        else $error("framing error not flagged");

    AST_SC_REFUSED: assert property (
        (ctrl_reg[USPF_B_SC] && evt.sc_nack) |=> flag_reg[USPF_B_FRM])
        else $error("smartcard refusal not flagged as framing");

    AST_PARITY_SET: assert property (
        evt.parity |=> flag_reg[USPF_B_PAR])
        else $error("parity error not flagged");

    // interrupt qualification
    AST_TXE_IRQ: assert property (
        (flag_reg[USPF_B_TXE] && ctrl_reg[USPF_B_TXE]) |-> irq)
        else $error("empty buffer did not interrupt");

    AST_OVR_IRQ: assert property (
        (flag_reg[USPF_B_OVR] && ctrl_reg[USPF_B_RXF]) |-> irq)
        else $error("overrun did not interrupt");

    // with every enable off the line must stay quiet
    AST_IRQ_QUIET: assert property (
        (ctrl_reg == USPF_CTRL_RST) |-> !irq)
        else $error("interrupt without an enable");

endmodule : uspf_status

`default_nettype wire

// [sim/uspf_remote.sv]
`default_nettype none

// far-end serial device: flow-control pin, line event pulses
// and the received character, each on request of the bench
module uspf_remote
    import uspf_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire uspf_evt_s  ev_req,     // event asked for, one cycle
    input  wire logic [8:0] word_req,   // character to deliver
    input  wire logic       cts_flip,   // toggle the flow-control pin
    output var  logic       clear_to_send_in_n,
    output var  uspf_evt_s  evt,
    output var  logic [8:0] rx_word
);
    timeunit 1ns;
    timeprecision 1ps;

    // detector pulses last exactly one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evt <= '0;
        end else begin
            evt <= ev_req;
        end
    end

    // the character only holds with rx_ready; otherwise it wanders,
    // so a late sample of it shows up as a wrong word
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_word <= USPF_WORD_RST;
        end else if (ev_req.rx_ready) begin
            rx_word <= word_req;
        end else begin
            rx_word <= ~rx_word;
        end
    end

    // pin idles high, meaning not clear to send
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clear_to_send_in_n <= 1'b1;
        end else if (cts_flip) begin
            clear_to_send_in_n <= ~clear_to_send_in_n;
        end
    end
endmodule : uspf_remote

`default_nettype wire

// [sim/uspf_status_tb_top.sv]
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module uspf_status_tb_top
    import uspf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // event bit positions inside uspf_evt_s
    localparam int EV_LIN = 8;
    localparam int EV_TXL = 7;
    localparam int EV_TXD = 6;
    localparam int EV_RXR = 5;
    localparam int EV_IDL = 4;
    localparam int EV_SCN = 0;
    localparam int EV_NOI = 3;
    localparam int EV_FRM = 2;
    localparam int EV_PAR = 1;
    localparam int EVI[4] = '{8, 3, 2, 1};   // lin, noise, framing, parity
    localparam int STI[4] = '{8, 2, 1, 0};   // matching status bits
    logic        clock, rst, wr_en, rd_en, cts_flip, cts_n;
    logic        tx_word_valid, irq;
    logic [7:0]  addr;
    logic [8:0]  word_req, rx_word, tx_word, w;
    logic [31:0] wr_data, rd_data, rd_data2, rdv, rdv2;
    uspf_evt_s   ev_req, evt;
    int          mismatches, n_checks, cyc;

    uspf_status #(.HAS_LIN(1'b1)) uspf_status_i (.clock(clock), .rst(rst),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .clear_to_send_in_n(cts_n), .evt(evt),
        .rx_word(rx_word), .tx_word(tx_word),
        .tx_word_valid(tx_word_valid), .irq(irq));
    // second port instance without the lin break flag
    uspf_status #(.HAS_LIN(1'b0)) uspf_status_b_i (.clock(clock),
        .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data2), .clear_to_send_in_n(cts_n),
        .evt(evt), .rx_word(rx_word), .tx_word(), .tx_word_valid(),
        .irq());
    uspf_remote uspf_remote_i (.clock(clock), .rst(rst), .ev_req(ev_req),
        .word_req(word_req), .cts_flip(cts_flip),
        .clear_to_send_in_n(cts_n), .evt(evt), .rx_word(rx_word));

    always #5 clock = ~clock;

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end

    function automatic logic [31:0] bv(input int unsigned b);
        return 32'h0000_0001 << b;
    endfunction : bv

    function automatic uspf_evt_s mk(input int k);
        return uspf_evt_s'(9'h001 << k);
    endfunction : mk

    // register write; a idle cycle follows so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr

    // register read; answer stands only in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        rdv = rd_data;
        rdv2 = rd_data2;
    endtask : rd

    task automatic chk_st(input logic [31:0] m, input logic [31:0] e);
        rd(USPF_OFS_STAT);
        `CHK(rdv & m, e)
    endtask : chk_st

    // one event pulse through the far-end model, then let it land
    task automatic ev(input int k, input logic [8:0] d);
        @(posedge clock);
        ev_req <= mk(k);
        word_req <= d;
        @(posedge clock);
        ev_req <= '0;
        @(posedge clock);
    endtask : ev

    task automatic chk_irq(input logic e);
        @(posedge clock);
        #1;
        `CHK(irq, e)
    endtask : chk_irq

    task automatic flip;
        @(posedge clock);
        cts_flip <= 1'b1;
        @(posedge clock);
        cts_flip <= 1'b0;
    endtask : flip

    task automatic test_done;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {wr_en, rd_en, cts_flip, addr, wr_data, word_req} = '0;
        ev_req = '0;
        void'($urandom(30852));
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        chk_st(32'hFFFF_FFFF, 32'h0000_00C0);
        // simple error and break flags: set, then cleared by one bit
        for (int i = 0; i < 4; i++) begin
            ev(EVI[i], 9'h000);
            chk_st(bv(STI[i]), bv(STI[i]));
            `CHK(rdv2[USPF_B_LIN], 1'b0)
            wr(USPF_OFS_CLR, bv(STI[i]));
            chk_st(bv(STI[i]), USPF_ZERO);
        end
        wr(USPF_OFS_STAT, 32'h0000_033F);
        chk_st(32'h0000_03FF, 32'h0000_00C0);
        // random characters through the receive register
        for (int i = 0; i < 16; i++) begin
            w = 9'($urandom);
            ev(EV_RXR, w);
            chk_st(bv(USPF_B_RXF), bv(USPF_B_RXF));
            rd(USPF_OFS_RDATA);
            `CHK(rdv, {23'h00_0000, w})
            chk_st(bv(USPF_B_RXF), USPF_ZERO);
        end
        // second word while full: overrun, first word kept
        ev(EV_RXR, w);
        ev(EV_RXR, ~w);
        chk_st(bv(USPF_B_OVR), bv(USPF_B_OVR));
        rd(USPF_OFS_RDATA);
        `CHK(rdv, {23'h00_0000, w})
        ev(EV_RXR, w);
        wr(USPF_OFS_CMD, bv(USPF_B_RXFL));
        chk_st(bv(USPF_B_RXF), USPF_ZERO);
        wr(USPF_OFS_CLR, 32'h0000_03FF);
        // idle sets once, rearmed only by a received word
        ev(EV_IDL, w);
        chk_st(bv(USPF_B_IDL), bv(USPF_B_IDL));
        wr(USPF_OFS_CLR, bv(USPF_B_IDL));
        ev(EV_IDL, w);
        chk_st(bv(USPF_B_IDL), USPF_ZERO);
        ev(EV_RXR, w);
        ev(EV_IDL, w);
        chk_st(bv(USPF_B_IDL), bv(USPF_B_IDL));
        rd(USPF_OFS_RDATA);
        // transmit side
        wr(USPF_OFS_CLR, bv(USPF_B_TXC));
        w = 9'($urandom);
        wr(USPF_OFS_TDATA, {23'h00_0000, w});
        chk_st(32'h0000_00C0, USPF_ZERO);
        `CHK(tx_word, w)
        `CHK(tx_word_valid, 1'b1)
        ev(EV_TXD, w);
        chk_st(bv(USPF_B_TXC), USPF_ZERO);
        ev(EV_TXL, w);
        chk_st(bv(USPF_B_TXE), bv(USPF_B_TXE));
        ev(EV_TXD, w);
        chk_st(bv(USPF_B_TXC), bv(USPF_B_TXC));
        wr(USPF_OFS_TDATA, {23'h00_0000, ~w});
        wr(USPF_OFS_CMD, bv(USPF_B_TXFL));
        chk_st(bv(USPF_B_TXE), bv(USPF_B_TXE));
        // flow-control pin level and change flag
        flip();
        chk_st(32'h0000_0600, 32'h0000_0600);
        wr(USPF_OFS_CLR, bv(USPF_B_CHG));
        flip();
        chk_st(32'h0000_0600, bv(USPF_B_CHG));
        // interrupt qualification, at most two enables at a time
        wr(USPF_OFS_CLR, 32'h0000_03FF);
        wr(USPF_OFS_CTRL, bv(USPF_B_CHG) | bv(USPF_B_PAR));
        chk_irq(1'b0);
        ev(EV_PAR, w);
        chk_irq(1'b1);
        wr(USPF_OFS_CLR, bv(USPF_B_PAR));
        chk_irq(1'b0);
        wr(USPF_OFS_CTRL, bv(USPF_B_OVR));
        ev(EV_NOI, w);
        chk_irq(1'b0);
        wr(USPF_OFS_CTRL, bv(USPF_B_OVR) | bv(USPF_B_MB));
        chk_irq(1'b1);
        wr(USPF_OFS_CLR, 32'h0000_03FF);
        ev(EV_FRM, w);
        chk_irq(1'b1);
        wr(USPF_OFS_CLR, 32'h0000_03FF);
        wr(USPF_OFS_CTRL, bv(USPF_B_RXF));
        ev(EV_RXR, w);
        ev(EV_RXR, w);
        rd(USPF_OFS_RDATA);
        chk_irq(1'b1);
        wr(USPF_OFS_CLR, bv(USPF_B_OVR));
        chk_irq(1'b0);
        wr(USPF_OFS_CTRL, bv(USPF_B_TXE) | bv(USPF_B_LIN));
        chk_irq(1'b1);
        wr(USPF_OFS_TDATA, {23'h00_0000, w});
        chk_irq(1'b0);
        ev(EV_LIN, w);
        chk_irq(1'b1);
        wr(USPF_OFS_CLR, 32'h0000_03FF);
        // smartcard refusal sets framing
        wr(USPF_OFS_CTRL, bv(USPF_B_SC));
        ev(EV_SCN, w);
        chk_st(bv(USPF_B_FRM), bv(USPF_B_FRM));
        rd(8'h40);
        `CHK(rdv, USPF_ZERO)
        // readback of the control and transmit data registers
        rd(USPF_OFS_CTRL);
        `CHK(rdv, bv(USPF_B_SC))
        rd(USPF_OFS_TDATA);
        `CHK(rdv, {23'h00_0000, w})
        // read answer stands one cycle only, then falls to zero
        @(posedge clock);
        #1;
        `CHK(rd_data, USPF_ZERO)
        // complete and idle interrupts
        wr(USPF_OFS_CLR, 32'h0000_03FF);
        wr(USPF_OFS_CTRL, bv(USPF_B_TXC) | bv(USPF_B_IDL));
        wr(USPF_OFS_CMD, bv(USPF_B_TXFL));
        ev(EV_TXD, w);
        chk_irq(1'b1);
        wr(USPF_OFS_CLR, bv(USPF_B_TXC));
        chk_irq(1'b0);
        ev(EV_IDL, w);
        chk_irq(1'b1);
        // reset in mid-run brings the power-up picture back
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        chk_st(32'hFFFF_FFFF, 32'h0000_00C0);
        `CHK(tx_word_valid, 1'b0)
        `CHK(irq, 1'b0)
        test_done();
    end
endmodule : uspf_status_tb_top

`default_nettype wire
